// ### verilog/fecmd_pkg.sv
// Package with opcodes, register layouts and timing counts for the flash command block
package fecmd_pkg;
   // Opcodes
   localparam logic [7:0] OP_SECTOR_ERASE_A = 8'hD7;
   localparam logic [7:0] OP_SECTOR_ERASE_B = 8'h20;
   localparam logic [7:0] OP_BLOCK32_ERASE  = 8'h52;
   localparam logic [7:0] OP_BLOCK64_ERASE  = 8'hD8;
   localparam logic [7:0] OP_CHIP_ERASE_A   = 8'hC7;
   localparam logic [7:0] OP_CHIP_ERASE_B   = 8'h60;
   localparam logic [7:0] OP_LATCH_SET      = 8'h06;
   localparam logic [7:0] OP_LATCH_CLEAR    = 8'h04;
   localparam logic [7:0] OP_STATUS_READ    = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE   = 8'h01;
   localparam logic [7:0] OP_FUNC_READ      = 8'h48;
   localparam logic [7:0] OP_FUNC_WRITE     = 8'h42;
   localparam logic [7:0] OP_QUAD_ENTER     = 8'h35;
   localparam logic [7:0] OP_QUAD_EXIT      = 8'hF5;
   // Address layout: 4 Kbyte sector, 32K block = 8 sectors, 64K block = 16
   localparam int ADDR_W       = 24;
   localparam int SECTOR_LSB   = 12;
   localparam int BLOCK32_LSB  = 15;
   localparam int BLOCK64_LSB  = 16;
   localparam int ADDR_BYTES   = 3;
   // Frame lengths in bits: opcode, opcode plus one byte, opcode plus address, cap
   localparam logic [5:0] BITS_OP    = 6'h08;
   localparam logic [5:0] BITS_DATA  = 6'h10;
   localparam logic [5:0] BITS_ADDR  = 6'h20;
   localparam logic [5:0] BITS_MAX   = 6'h28;
   // Status register fields
   localparam int SR_BUSY      = 0;
   localparam int SR_WEL       = 1;
   localparam int SR_BP_LSB    = 2;
   localparam int SR_QE        = 6;
   localparam int SR_STATUS_WRITE_DISABLE_BIT      = 7;
   localparam logic [7:0] SR_NV_MASK = 8'hFC;
   localparam logic [7:0] SR_RESET   = 8'h00;
   // Function register fields
   localparam int FR_RSTEN     = 0;
   localparam int FR_IRL_LSB   = 4;
   localparam logic [7:0] FR_W_MASK  = 8'hF1;
   localparam logic [7:0] FR_RESET   = 8'hF0;
   // Erase kinds
   typedef enum logic [1:0] {ERASE_SECTOR, ERASE_BLOCK32, ERASE_BLOCK64,
                             ERASE_CHIP} fecmd_erase_type;
   // Internal operation time (cycles of clk)
   localparam logic [15:0] OP_CYCLES = 16'h0400;
endpackage

// ### verilog/fecmd_ctrl.sv
// Command decoder and write-enable control of a serial NOR flash
`timescale 1ns/100ps
module fecmd_ctrl
   import fecmd_pkg::*;
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst_n,
   // Serial link pins
   input  wire logic                sel_n,
   input  wire logic                sclk,
   input  wire logic [3:0]          io_in,
   output logic      [3:0]          io_out,
   output logic      [3:0]          io_oe_n,
   // Array erase request
   output logic                     erase_start,
   output fecmd_erase_type          erase_kind,
   output logic      [ADDR_W-1:0]   erase_addr,
   // State visible to the rest of the device
   output logic                     busy_flag,
   output logic                     write_enable_latch,
   output logic                     four_bit_command_mode,
   output logic      [7:0]          status_reg,
   output logic      [7:0]          function_reg
);
   // Reset release
   logic       rst_s1_reg, rst_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_reg <= 1'b0;
         rst_reg    <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_reg    <= rst_s1_reg;
      end
   end
   wire srst_n = rst_reg;

   // Pin synchronisers, first stage read only by the second
   logic [5:0] pin_s1_reg, pin_s2_reg;
   logic       sclk_d_reg;
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         pin_s1_reg <= 6'h01;
         pin_s2_reg <= 6'h01;
         sclk_d_reg <= 1'b0;
      end else begin
         pin_s1_reg <= {io_in, sclk, sel_n};
         pin_s2_reg <= pin_s1_reg;
         sclk_d_reg <= pin_s2_reg[1];
      end
   end
   wire       sel_n_s = pin_s2_reg[0];
   wire [3:0] io_s    = pin_s2_reg[5:2];
   wire       rise    = pin_s2_reg[1] & ~sclk_d_reg;
   wire       fall    = ~pin_s2_reg[1] & sclk_d_reg;
   logic      sel_d_reg;
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) sel_d_reg <= 1'b1;
      else         sel_d_reg <= sel_n_s;
   end
   wire sel_rise = sel_n_s & ~sel_d_reg;

   // Shift register and bit counter; four bits a clock in quad mode
   logic [7:0]  shift_reg;
   logic [7:0]  opcode_reg;
   logic [5:0]  bits_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [7:0]  data_reg;
   logic        data_ok_reg;
   wire  [2:0]  step = four_bit_command_mode ? 3'h4 : 3'h1;
   wire  [7:0]  shift_next = four_bit_command_mode ? {shift_reg[3:0], io_s}
                                                   : {shift_reg[6:0], io_s[0]};
   wire  [5:0]  bits_next  = bits_reg + {3'h0, step};
   // Bits past the 40-bit cap are dropped so the counter cannot wrap
   wire         take_bit   = !sel_n_s && rise && (bits_reg < BITS_MAX);
   wire         byte_end   = take_bit && (bits_next[2:0] == 3'h0);
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         shift_reg <= 8'h00;
         bits_reg  <= 6'h00;
      end else if (sel_n_s) begin
         bits_reg <= 6'h00;
      end else if (take_bit) begin
         shift_reg <= shift_next;
         bits_reg  <= bits_next;
      end
   end

   // Opcode byte ends after 8 serial or 2 quad clocks
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         opcode_reg <= 8'h00;
      end else if (take_bit && bits_next == BITS_OP) begin
         opcode_reg <= shift_next;
      end
   end

   // Address bytes, most significant first
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         addr_reg <= '0;
      end else if (byte_end && bits_next > BITS_OP && bits_next <= BITS_ADDR) begin
         addr_reg <= {addr_reg[15:0], shift_next};
      end
   end

   // First byte after the opcode; flag keeps a cut frame from writing
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         data_reg    <= 8'h00;
         data_ok_reg <= 1'b0;
      end else if (take_bit && bits_next == BITS_OP) begin
         data_ok_reg <= 1'b0;
      end else if (take_bit && bits_next == BITS_DATA) begin
         data_reg    <= shift_next;
         data_ok_reg <= 1'b1;
      end
   end
   wire [5:0] nbits = bits_reg;

   // Internal operation timer drives the busy flag
   logic [15:0] timer_reg;
   logic        busy_reg;
   logic        done;
   assign done = busy_reg && (timer_reg == 16'h0000);
   assign busy_flag = busy_reg;

   // Command accepted on select rise with the right byte count
   function automatic logic is_chip_erase(input logic [7:0] op);
      is_chip_erase = (op == OP_CHIP_ERASE_A) || (op == OP_CHIP_ERASE_B);
   endfunction
   function automatic logic is_erase(input logic [7:0] op);
      is_erase = (op == OP_SECTOR_ERASE_A) || (op == OP_SECTOR_ERASE_B) ||
                 (op == OP_BLOCK32_ERASE) || (op == OP_BLOCK64_ERASE) ||
                 is_chip_erase(op);
   endfunction
   wire ended    = sel_rise && !busy_reg;
   wire op_byte  = ended && nbits == BITS_OP;
   wire adr_done = ended && nbits == BITS_ADDR;
   wire is_chip  = is_chip_erase(opcode_reg);
   wire go_erase = write_enable_latch && is_erase(opcode_reg) &&
                   (is_chip ? op_byte : adr_done && !is_chip);
   wire go_sr    = write_enable_latch && opcode_reg == OP_STATUS_WRITE &&
                   ended && nbits == BITS_DATA && data_ok_reg;
   wire go_fr    = write_enable_latch && opcode_reg == OP_FUNC_WRITE &&
                   ended && nbits == BITS_DATA && data_ok_reg;

   // Busy timer: erase and register writes are self-timed
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         busy_reg  <= 1'b0;
         timer_reg <= 16'h0000;
      end else if (go_erase || go_sr || go_fr) begin
         busy_reg  <= 1'b1;
         timer_reg <= OP_CYCLES;
      end else if (busy_reg) begin
         if (done) busy_reg <= 1'b0;
         else      timer_reg <= timer_reg - 16'h0001;
      end
   end

   // Erase request to the array; kind from the opcode, base from address alignment
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         erase_start <= 1'b0;
         erase_kind  <= ERASE_SECTOR;
         erase_addr  <= '0;
      end else begin
         erase_start <= go_erase;
         if (go_erase) begin
            case (opcode_reg)
               OP_BLOCK32_ERASE: begin
                  erase_kind <= ERASE_BLOCK32;
                  erase_addr <= {addr_reg[ADDR_W-1:BLOCK32_LSB], 15'h0000};
               end
               OP_BLOCK64_ERASE: begin
                  erase_kind <= ERASE_BLOCK64;
                  erase_addr <= {addr_reg[ADDR_W-1:BLOCK64_LSB], 16'h0000};
               end
               OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
                  erase_kind <= ERASE_CHIP;
                  erase_addr <= '0;
               end
               default: begin
                  erase_kind <= ERASE_SECTOR;
                  erase_addr <= {addr_reg[ADDR_W-1:SECTOR_LSB], 12'h000};
               end
            endcase
         end
      end
   end

   // Write-enable latch; completion clear wins as the op ends
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         write_enable_latch <= 1'b0;
      end else if (done) begin
         write_enable_latch <= 1'b0;
      end else if (op_byte && opcode_reg == OP_LATCH_SET) begin
         write_enable_latch <= 1'b1;
      end else if (op_byte && opcode_reg == OP_LATCH_CLEAR) begin
         write_enable_latch <= 1'b0;
      end
   end

   // Non-volatile status bits and function register
   logic [7:0] sr_nv_reg;
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         sr_nv_reg    <= SR_RESET;
         function_reg <= FR_RESET;
      end else begin
         if (go_sr) sr_nv_reg <= data_reg & SR_NV_MASK;
         if (go_fr) function_reg <= (function_reg & ~FR_W_MASK) |
                                    (data_reg & FR_W_MASK);
      end
   end
   always_comb begin
      status_reg         = sr_nv_reg;
      status_reg[SR_BUSY] = busy_reg;
      status_reg[SR_WEL]  = write_enable_latch;
   end

   // Four-bit command mode; exit only as a two-clock quad cycle
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         four_bit_command_mode <= 1'b0;
      end else if (op_byte) begin
         if (!four_bit_command_mode && opcode_reg == OP_QUAD_ENTER)
            four_bit_command_mode <= 1'b1;
         else if (four_bit_command_mode && opcode_reg == OP_QUAD_EXIT)
            four_bit_command_mode <= 1'b0;
      end
   end

   // Read answer: status or function register shifted out on falling edges
   logic [7:0] out_reg;
   logic       rd_reg;
   wire        rd_cmd = opcode_reg == OP_STATUS_READ ||
                        (opcode_reg == OP_FUNC_READ && !busy_reg);
   wire        rd_fall = !sel_n_s && fall && nbits >= BITS_OP && rd_cmd;
   // Read active flag, dropped as soon as select goes high
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         rd_reg <= 1'b0;
      end else if (sel_n_s) begin
         rd_reg <= 1'b0;
      end else if (rd_fall) begin
         rd_reg <= 1'b1;
      end
   end
   // Snapshot once per frame; a status change mid-read shows on the next poll
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         out_reg <= 8'h00;
      end else if (rd_fall) begin
         if (nbits == BITS_OP || !rd_reg)
            out_reg <= (opcode_reg == OP_STATUS_READ) ? status_reg
                                                      : function_reg;
         else if (four_bit_command_mode)
            out_reg <= {out_reg[3:0], 4'h0};
         else
            out_reg <= {out_reg[6:0], 1'b0};
      end
   end
   // Data output: serial on line 1, quad on all four lines
   always_comb begin
      io_out  = 4'h0;
      io_oe_n = 4'hF;
      if (rd_reg && !sel_n_s) begin
         if (four_bit_command_mode) begin
            io_out  = out_reg[7:4];
            io_oe_n = 4'h0;
         end else begin
            io_out[1]  = out_reg[7];
            io_oe_n[1] = 1'b0;
         end
      end
   end
endmodule

// ### testbench/fecmd_assertions.sv
// Port-level checker for erase, latch and mode behaviour
`timescale 1ns/100ps
module fecmd_chk
   import fecmd_pkg::*;
(
   // Clock, reset and link pins
   input logic            clk,
   input logic            rst_n,
   input logic            sel_n,
   input logic [3:0]      io_oe_n,
   // Outputs under watch
   input logic            erase_start,
   input logic            busy_flag,
   input logic            write_enable_latch,
   input logic            four_bit_command_mode,
   input fecmd_erase_type erase_kind,
   input logic [23:0]     erase_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [15:0] busy_cnt_reg;
   // Busy length counter, restarts while idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         busy_cnt_reg <= 16'h0000;
      else
         busy_cnt_reg <= busy_flag ? busy_cnt_reg + 16'h0001 : 16'h0000;
   end
   sequence s_desel;
      sel_n [*5];
   endsequence
   sequence s_busy_run;
      busy_flag ##1 busy_flag;
   endsequence
   AST_ERASE_LATCH: assert property (erase_start |-> write_enable_latch && !$past(busy_flag))
      else $error("erase started without latch or while busy");
   AST_ERASE_DESEL: assert property (erase_start |-> sel_n && $past(sel_n, 3))
      else $error("erase started while selected");
   AST_ERASE_BUSY: assert property (erase_start |-> ##[0:1] busy_flag)
      else $error("busy not raised by erase");
   AST_SECTOR_ALIGN: assert property (erase_start && erase_kind == ERASE_SECTOR
      |-> erase_addr[11:0] == 12'h000)
      else $error("sector base not aligned");
   AST_BLOCK_ALIGN: assert property (erase_start && erase_kind == ERASE_BLOCK64
      |-> erase_addr[15:0] == 16'h0000)
      else $error("block base not aligned");
   AST_BLOCK32_ALIGN: assert property (erase_start && erase_kind == ERASE_BLOCK32
      |-> erase_addr[14:0] == 15'h0000)
      else $error("half block base not aligned");
   AST_BUSY_LEN: assert property ($fell(busy_flag)
      |-> busy_cnt_reg >= OP_CYCLES && busy_cnt_reg <= OP_CYCLES + 16'h0002)
      else $error("busy length wrong");
   AST_LATCH_AUTO: assert property ($fell(busy_flag) |-> !write_enable_latch)
      else $error("latch kept after completion");
   AST_BUSY_IGNORE: assert property (s_busy_run
      |-> !$rose(write_enable_latch) && $stable(four_bit_command_mode))
      else $error("command acted on while busy");
   AST_LATCH_SET: assert property ($rose(write_enable_latch) |-> $past(sel_n, 2) && !busy_flag)
      else $error("latch set outside a closed frame");
   AST_MODE_SWITCH: assert property ($changed(four_bit_command_mode) |-> $past(sel_n, 2))
      else $error("mode changed inside a frame");
   AST_OE_IDLE: assert property (s_desel |-> io_oe_n == 4'hF)
      else $error("pins driven while deselected");
endmodule
bind fecmd_ctrl fecmd_chk chk_u (.clk(clk), .rst_n(rst_n), .sel_n(sel_n), .io_oe_n(io_oe_n),
   .erase_start(erase_start), .busy_flag(busy_flag), .write_enable_latch(write_enable_latch),
   .four_bit_command_mode(four_bit_command_mode), .erase_kind(erase_kind),
   .erase_addr(erase_addr));

// ### testbench/fecmd_host.sv
// Host link model: frames commands onto select, link clock and IO pins
`timescale 1ns/100ps
module fecmd_host (
   // Clock and device pins
   input  wire logic       clk,
   input  wire logic [3:0] io_out,
   input  wire logic [3:0] io_oe_n,
   output logic            sel_n,
   output logic            sclk,
   output logic [3:0]      io_in
);
   initial begin
      sel_n = 1'b1;
      sclk = 1'b0;
      io_in = 4'hF;
   end
   // Half of the 160 ns link clock
   task automatic half();
      repeat (4) @(posedge clk);
   endtask
   // One frame of n bits; link clock stands low outside frames
   task automatic frame(input logic [31:0] d, input int n, input logic quad,
                        output logic [7:0] rd);
      int w;
      w = quad ? 4 : 1;
      rd = 8'h00;
      sel_n <= 1'b0;
      for (int i = n - w; i >= 0; i -= w) begin
         io_in <= quad ? d[i+:4] : {3'b111, d[i]};
         half();
         sclk <= 1'b1;
         half();
         // A line the device does not enable reads inverted, so no stale value passes
         rd = quad ? {rd[3:0], io_out ^ io_oe_n} : {rd[6:0], io_out[1] ^ io_oe_n[1]};
         sclk <= 1'b0;
      end
      half();
      sel_n <= 1'b1;
      io_in <= ~io_in; // Released lines show no stale value
      repeat (8) @(posedge clk);
   endtask
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the flash command block
`timescale 1ns/100ps
module tb_top;
   import fecmd_pkg::*;
   logic            clk = 1'b0;
   logic            rst_n = 1'b0;
   logic            sel_n, sclk, erase_start, busy_flag, write_enable_latch, four_bit_command_mode;
   logic [3:0]      io_in, io_out, io_oe_n;
   fecmd_erase_type erase_kind, got_kind;
   logic [23:0]     erase_addr, got_addr;
   logic [7:0]      status_reg, function_reg, rd;
   int              fails = 0;
   int              checks = 0;
   int              starts = 0;
   always #10 clk = ~clk;
   fecmd_ctrl dut_u (.clk(clk), .rst_n(rst_n), .sel_n(sel_n), .sclk(sclk), .io_in(io_in),
      .io_out(io_out), .io_oe_n(io_oe_n), .erase_start(erase_start), .erase_kind(erase_kind),
      .erase_addr(erase_addr), .busy_flag(busy_flag), .write_enable_latch(write_enable_latch),
      .four_bit_command_mode(four_bit_command_mode), .status_reg(status_reg),
      .function_reg(function_reg));
   fecmd_host host_u (.clk(clk), .io_out(io_out), .io_oe_n(io_oe_n), .sel_n(sel_n),
      .sclk(sclk), .io_in(io_in));
   // Capture each erase request
   always @(posedge clk) begin
      if (erase_start === 1'b1) begin
         starts++;
         got_kind = erase_kind;
         got_addr = erase_addr;
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmd(input logic [31:0] d, input int n, input logic q = 1'b0);
      host_u.frame(d, n, q, rd);
   endtask
   // Bounded wait for the end of a busy period
   task automatic wait_idle();
      for (int i = 0; i < 1200 && busy_flag !== 1'b0; i++)
         @(posedge clk);
      chk("busy end", 0, busy_flag);
   endtask
   task automatic t_refuse();
      chk("oe idle", 4'hF, io_oe_n);
      cmd({8'hD7, 24'h001000}, 32);
      cmd({8'h01, 8'hFC}, 16);
      cmd({8'h42, 8'h01}, 16);
      chk("starts", 0, starts);
      chk("latch", 0, write_enable_latch);
      chk("status", 8'h00, status_reg);
      chk("func", 8'hF0, function_reg);
      $display("refusal test done");
   endtask
   task automatic t_erase();
      logic [7:0] ops [6] = '{8'hD7, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
      logic [23:0] ad [4] = '{24'h0AB000, 24'h0AB000, 24'h0A8000, 24'h0A0000};
      fecmd_erase_type k [6] = '{ERASE_SECTOR, ERASE_SECTOR, ERASE_BLOCK32, ERASE_BLOCK64,
                                 ERASE_CHIP, ERASE_CHIP};
      for (int i = 0; i < 6; i++) begin
         cmd(8'h06, 8);
         chk("latch set", 1, write_enable_latch);
         if (i < 4)
            cmd({ops[i], 24'h0ABCDE}, 32);
         else
            cmd(ops[i], 8);
         chk("starts", i + 1, starts);
         chk("kind", k[i], got_kind);
         if (i < 4)
            chk("base", ad[i], got_addr);
         chk("busy", 1, busy_flag);
         cmd(8'h35, 8);
         chk("mode", 0, four_bit_command_mode);
         cmd({8'h05, 8'h00}, 16);
         chk("status busy", 8'h03, rd);
         wait_idle();
         chk("latch auto", 0, write_enable_latch);
      end
      $display("erase test done");
   endtask
   task automatic t_regs();
      cmd(8'h06, 8);
      cmd({8'h01, 8'h7E}, 16);
      wait_idle();
      chk("status nv", 8'h7C, status_reg);
      cmd(8'h06, 8);
      cmd(8'h04, 8);
      chk("latch clr", 0, write_enable_latch);
      cmd(8'h06, 8);
      cmd({8'h42, 8'h5F}, 16);
      wait_idle();
      cmd({8'h48, 8'h00}, 16);
      chk("func read", 8'h51, rd);
      $display("register test done");
   endtask
   task automatic t_quad();
      cmd(8'hF5, 8);
      chk("mode off", 0, four_bit_command_mode);
      cmd(8'h35, 8);
      chk("mode on", 1, four_bit_command_mode);
      cmd(8'hF5, 8);
      chk("mode held", 1, four_bit_command_mode);
      cmd(8'h06, 8, 1'b1);
      chk("quad latch", 1, write_enable_latch);
      cmd({8'h05, 8'h00}, 16, 1'b1);
      chk("quad status", 8'h7E, rd);
      cmd(8'h04, 8, 1'b1);
      cmd(8'hF5, 8, 1'b1);
      chk("mode exit", 0, four_bit_command_mode);
      $display("quad mode test done");
   endtask
   task automatic stop_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_refuse();
      t_erase();
      t_regs();
      t_quad();
      stop_test();
   end
   // Watchdog, about four times the expected run
   initial begin
      #1000000;
      fails++;
      stop_test();
   end
endmodule
